// >>> hdl/dppm_defines.vh
/*
 Register offsets, reset values and field positions for the DSP port
 pin-function multiplexer. Definitions only; included by the top module and the testbench top.
*/
`ifndef DPPM_DEFINES_VH
`define DPPM_DEFINES_VH

`define DPPM_AW          8
`define DPPM_DW          8

`define DPPM_PB_OUT      8'h00
`define DPPM_PB_DIR      8'h01
`define DPPM_PB_MCELL    8'h02
`define DPPM_PB_MSRC     8'h03
`define DPPM_PB_SLEW     8'h04
`define DPPM_PB_OD       8'h05
`define DPPM_PB_IN       8'h06
`define DPPM_PC_OUT      8'h08
`define DPPM_PC_DIR      8'h09
`define DPPM_PC_MCELL    8'h0a
`define DPPM_PC_OD       8'h0b
`define DPPM_PC_IN       8'h0c
`define DPPM_PROG_CTRL   8'h10
`define DPPM_PAGE        8'h11
`define DPPM_INT_STATUS  8'h12
`define DPPM_INT_MASK    8'h13
`define DPPM_STATUS      8'h14

`define DPPM_RST_VAL     8'h00
`define DPPM_SLEW_MASK   8'h0f
`define DPPM_PB_OD_MASK  8'hf8

`define DPPM_CTL_JTAG    0
`define DPPM_CTL_ENH     1
`define DPPM_CTL_RDYBSY  2
`define DPPM_CTL_MASK    8'h07

`define DPPM_INT_DONE    0
`define DPPM_INT_BYTERD  1
`define DPPM_INT_MASKALL 8'h03

`endif

// >>> hdl/dppm_pin_cell.v
/*
 One multifunction pin: alternate function, macrocell output, direct
 I/O or plain input, with an open-drain option. Output enable is low
 while the pin is driven. Assumes all inputs are on i_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module dppm_pin_cell (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_clr,
  input  wire i_alt_en,
  input  wire i_alt_val,
  input  wire i_alt_drive,
  input  wire i_mcell_en,
  input  wire i_mcell_val,
  input  wire i_dir,
  input  wire i_io_val,
  input  wire i_od,
  input  wire i_od_in_mcell,
  output reg  o_pin,
  output reg  o_pin_oe_n
);
  reg next_val;
  reg next_drive;
  reg use_od;

  always @* begin
    next_val   = 1'b0;
    next_drive = 1'b0;
    use_od     = 1'b0;
    if (i_alt_en) begin
      next_val   = i_alt_val;
      next_drive = i_alt_drive;
    end else if (i_mcell_en) begin
      next_val   = i_mcell_val;
      next_drive = 1'b1;
      use_od     = i_od & i_od_in_mcell;
    end else if (i_dir) begin
      next_val   = i_io_val;
      next_drive = 1'b1;
      use_od     = i_od;
    end
    // Open drain only pulls low; a high releases the pin
    if (use_od) begin
      next_drive = next_drive & ~next_val;
      next_val   = 1'b0;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin      <= 1'b0;
      o_pin_oe_n <= 1'b1;
    end else if (i_clr) begin
      o_pin      <= 1'b0;
      o_pin_oe_n <= 1'b1;
    end else begin
      o_pin      <= next_val;
      o_pin_oe_n <= ~next_drive;
    end
  end
endmodule // dppm_pin_cell
`default_nettype wire

// >>> hdl/dppm_sync2.v
/*
 Two-flop synchroniser for a bus of independent levels.
 Assumes each bit is a slow level; no word coherence is offered.
*/
`timescale 1ns/1ns
`default_nettype none
module dppm_sync2 #(
  parameter W   = 1,
  parameter RST = 0
) (
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire [W-1:0] i_d,
  output reg  [W-1:0] o_q
);
  reg [W-1:0] meta;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= {W{RST[0]}};
      o_q  <= {W{RST[0]}};
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule // dppm_sync2
`default_nettype wire

// >>> hdl/dppm_top.v
/*
 Pin-function multiplexer for a DSP companion device: host data lanes,
 read and byte-memory-select strobes, system reset pin, Port B and Port C
 function selection, programming pins and flash ready/busy.
 Assumes a 10 MHz clock, pins arriving asynchronously, flash and logic
 array signals on the same clock, and a simple strobe register port.
*/
// Decided for this implementation: the register offsets and the address-and-strobe port.
// Functional notes
// - Memory read runs only while the read strobe pin is low.
// - Byte-memory-select low qualifies accesses in byte DMA space.
// - System reset low returns ports, page and configuration registers to reset.
// - Host data pin 0..7 carries DSP data bits 8..15.
// - Each Port B pin: direct I/O, macrocell output or logic input.
// - Port B pins 0..3 select CMOS or high slew drive per pin.
// - Port B pins 3..7 select CMOS or open-drain output per pin.
// - Each Port C pin: direct I/O, macrocell output or logic input.
// - Programming enabled: Port C 0,1,5,6 are TMS, TCK, TDI, TDO.
// - Port C 3,4 optionally carry enhanced program status and error.
// - Port C 3 optionally shows flash ready/busy during programming.
// - Port C 2 logic input can carry DSP address bit 16.
// - Port C 7 logic input can carry DSP address bit 17.
// - Port C in general I/O selects CMOS or open drain per pin.
`timescale 1ns/1ns
`default_nettype none
`include "dppm_defines.vh"
module dppm_top (
  input  wire       I_CLK,
  input  wire       I_RST,
  input  wire       I_SYS_RESET_N,
  input  wire       I_READ_STROBE_IN_N,
  input  wire       I_BYTE_SPACE_SELECT_IN_N,
  input  wire [7:0] I_HOST_DATA_PINS,
  output wire [7:0] O_HOST_DATA_PINS,
  output wire       O_HOST_DATA_PINS_OE_N,
  input  wire [7:0] I_PORT_B_PINS,
  output wire [7:0] O_PORT_B_PINS,
  output wire [7:0] O_PORT_B_PINS_OE_N,
  output wire [3:0] O_PORT_B_FAST_SLEW,
  input  wire [7:0] I_PORT_C_PINS,
  output wire [7:0] O_PORT_C_PINS,
  output wire [7:0] O_PORT_C_PINS_OE_N,
  input  wire [7:0] I_OUTPUT_MACROCELL_GROUP_AB,
  input  wire [7:0] I_OUTPUT_MACROCELL_GROUP_BC,
  output wire [7:0] O_PORT_B_LOGIC_IN,
  output wire [7:0] O_PORT_C_LOGIC_IN,
  output wire       O_ADDR_BIT16,
  output wire       O_ADDR_BIT17,
  input  wire [7:0] I_MEM_RDATA,
  output reg        O_MEM_READ,
  output wire       O_BYTE_SPACE_ACCESS,
  output wire [7:0] O_HOST_WRITE_DATA,
  output reg  [7:0] O_PAGE,
  input  wire       I_FLASH_BUSY,
  input  wire       I_JTAG_TDO,
  input  wire       I_ENHANCED_PROGRAM_STATUS,
  input  wire       I_ENHANCED_PROGRAM_ERROR,
  output wire       O_JTAG_TMS,
  output wire       O_JTAG_TCK,
  output wire       O_JTAG_TDI,
  output wire       O_JTAG_ACTIVE,
  input  wire [7:0] I_ADDR,
  input  wire [7:0] I_WDATA,
  input  wire       I_WR,
  input  wire       I_RD,
  output reg  [7:0] O_RDATA,
  output wire       O_IRQ
);
  wire [7:0] pb_in;
  wire [7:0] pc_in;
  wire [7:0] hd_in;
  wire [2:0] ctl_in;
  wire       rd_n;
  wire       bms_n;
  wire       sys_rst_n;
  wire       sys_clr;

  reg  [7:0] pb_out;
  reg  [7:0] pb_dir;
  reg  [7:0] pb_mcell;
  reg  [7:0] pb_msrc;
  reg  [3:0] pb_slew;
  reg  [7:0] pb_od;
  reg  [7:0] pc_out;
  reg  [7:0] pc_dir;
  reg  [7:0] pc_mcell;
  reg  [7:0] pc_od;
  reg  [2:0] prog_ctrl;
  reg  [1:0] int_status;
  reg  [1:0] int_mask;
  reg  [7:0] mem_data;
  reg        busy_d;
  reg        mem_read_d;

  wire       jtag_en;
  wire       enh_en;
  wire       rdybsy_en;
  wire       done_evt;
  wire       byte_rd_evt;
  wire [7:0] pb_mcell_val;
  wire [7:0] pc_alt_en;
  wire [7:0] pc_alt_val;
  wire [7:0] pc_alt_drive;
  wire       wr_int_status;
  reg  [7:0] next_rdata;

  // Every pin level is foreign to I_CLK
  dppm_sync2 #(.W(8), .RST(0)) u_sync_pb (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_d   (I_PORT_B_PINS),
    .o_q   (pb_in)
  );

  dppm_sync2 #(.W(8), .RST(0)) u_sync_pc (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_d   (I_PORT_C_PINS),
    .o_q   (pc_in)
  );

  dppm_sync2 #(.W(8), .RST(0)) u_sync_hd (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_d   (I_HOST_DATA_PINS),
    .o_q   (hd_in)
  );

  // Strobes idle high; reset pin sync also starts high, so it reads released
  dppm_sync2 #(.W(3), .RST(3)) u_sync_ctl (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_d   ({I_SYS_RESET_N, I_BYTE_SPACE_SELECT_IN_N, I_READ_STROBE_IN_N}),
    .o_q   (ctl_in)
  );

  assign rd_n      = ctl_in[0];
  assign bms_n     = ctl_in[1];
  // Sync reset starts at 1 but I_RST already covers power-up; keeps it low
  assign sys_rst_n = ctl_in[2];
  assign sys_clr   = ~sys_rst_n;

  assign jtag_en   = prog_ctrl[`DPPM_CTL_JTAG];
  assign enh_en    = prog_ctrl[`DPPM_CTL_ENH] & jtag_en;
  assign rdybsy_en = prog_ctrl[`DPPM_CTL_RDYBSY];

  assign wr_int_status = I_WR & (I_ADDR == `DPPM_INT_STATUS);

  // Configuration registers; all clear on the system reset pin too
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pb_out    <= `DPPM_RST_VAL;
      pb_dir    <= `DPPM_RST_VAL;
      pb_mcell  <= `DPPM_RST_VAL;
      pb_msrc   <= `DPPM_RST_VAL;
      pb_slew   <= 4'h0;
      pb_od     <= `DPPM_RST_VAL;
      pc_out    <= `DPPM_RST_VAL;
      pc_dir    <= `DPPM_RST_VAL;
      pc_mcell  <= `DPPM_RST_VAL;
      pc_od     <= `DPPM_RST_VAL;
      prog_ctrl <= 3'h0;
      O_PAGE    <= `DPPM_RST_VAL;
      int_mask  <= 2'h0;
    end else if (sys_clr) begin
      pb_out    <= `DPPM_RST_VAL;
      pb_dir    <= `DPPM_RST_VAL;
      pb_mcell  <= `DPPM_RST_VAL;
      pb_msrc   <= `DPPM_RST_VAL;
      pb_slew   <= 4'h0;
      pb_od     <= `DPPM_RST_VAL;
      pc_out    <= `DPPM_RST_VAL;
      pc_dir    <= `DPPM_RST_VAL;
      pc_mcell  <= `DPPM_RST_VAL;
      pc_od     <= `DPPM_RST_VAL;
      prog_ctrl <= 3'h0;
      O_PAGE    <= `DPPM_RST_VAL;
      int_mask  <= 2'h0;
    end else if (I_WR) begin
      case (I_ADDR)
        `DPPM_PB_OUT:    pb_out    <= I_WDATA;
        `DPPM_PB_DIR:    pb_dir    <= I_WDATA;
        `DPPM_PB_MCELL:  pb_mcell  <= I_WDATA;
        `DPPM_PB_MSRC:   pb_msrc   <= I_WDATA;
        `DPPM_PB_SLEW:   pb_slew   <= I_WDATA[3:0];
        `DPPM_PB_OD:     pb_od     <= I_WDATA & `DPPM_PB_OD_MASK;
        `DPPM_PC_OUT:    pc_out    <= I_WDATA;
        `DPPM_PC_DIR:    pc_dir    <= I_WDATA;
        `DPPM_PC_MCELL:  pc_mcell  <= I_WDATA;
        `DPPM_PC_OD:     pc_od     <= I_WDATA;
        `DPPM_PROG_CTRL: prog_ctrl <= I_WDATA[2:0];
        `DPPM_PAGE:      O_PAGE    <= I_WDATA;
        `DPPM_INT_MASK:  int_mask  <= I_WDATA[1:0];
        default: begin
        end
      endcase
    end
  end

  assign O_PORT_B_FAST_SLEW = pb_slew;

  // Macrocell source per Port B pin: 0 takes group AB, 1 takes group BC
  assign pb_mcell_val = (I_OUTPUT_MACROCELL_GROUP_AB & ~pb_msrc) |
                        (I_OUTPUT_MACROCELL_GROUP_BC & pb_msrc);

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pb
      dppm_pin_cell u_cell (
        .i_clk         (I_CLK),
        .i_rst         (I_RST),
        .i_clr         (sys_clr),
        .i_alt_en      (1'b0),
        .i_alt_val     (1'b0),
        .i_alt_drive   (1'b0),
        .i_mcell_en    (pb_mcell[g]),
        .i_mcell_val   (pb_mcell_val[g]),
        .i_dir         (pb_dir[g]),
        .i_io_val      (pb_out[g]),
        .i_od          (pb_od[g]),
        .i_od_in_mcell (1'b1),
        .o_pin         (O_PORT_B_PINS[g]),
        .o_pin_oe_n    (O_PORT_B_PINS_OE_N[g])
      );
    end
  endgenerate

  // Port C alternate functions; enhanced status outranks ready/busy on pin 3
  assign pc_alt_en[0]    = jtag_en;
  assign pc_alt_val[0]   = 1'b0;
  assign pc_alt_drive[0] = 1'b0;
  assign pc_alt_en[1]    = jtag_en;
  assign pc_alt_val[1]   = 1'b0;
  assign pc_alt_drive[1] = 1'b0;
  assign pc_alt_en[2]    = 1'b0;
  assign pc_alt_val[2]   = 1'b0;
  assign pc_alt_drive[2] = 1'b0;
  assign pc_alt_en[3]    = enh_en | rdybsy_en;
  assign pc_alt_val[3]   = enh_en ? I_ENHANCED_PROGRAM_STATUS : ~I_FLASH_BUSY;
  assign pc_alt_drive[3] = 1'b1;
  assign pc_alt_en[4]    = enh_en;
  assign pc_alt_val[4]   = I_ENHANCED_PROGRAM_ERROR;
  assign pc_alt_drive[4] = 1'b1;
  assign pc_alt_en[5]    = jtag_en;
  assign pc_alt_val[5]   = 1'b0;
  assign pc_alt_drive[5] = 1'b0;
  assign pc_alt_en[6]    = jtag_en;
  assign pc_alt_val[6]   = I_JTAG_TDO;
  assign pc_alt_drive[6] = 1'b1;
  assign pc_alt_en[7]    = 1'b0;
  assign pc_alt_val[7]   = 1'b0;
  assign pc_alt_drive[7] = 1'b0;

  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pc
      dppm_pin_cell u_cell (
        .i_clk         (I_CLK),
        .i_rst         (I_RST),
        .i_clr         (sys_clr),
        .i_alt_en      (pc_alt_en[g]),
        .i_alt_val     (pc_alt_val[g]),
        .i_alt_drive   (pc_alt_drive[g]),
        .i_mcell_en    (pc_mcell[g]),
        .i_mcell_val   (I_OUTPUT_MACROCELL_GROUP_BC[g]),
        .i_dir         (pc_dir[g]),
        .i_io_val      (pc_out[g]),
        .i_od          (pc_od[g]),
        .i_od_in_mcell (1'b0),
        .o_pin         (O_PORT_C_PINS[g]),
        .o_pin_oe_n    (O_PORT_C_PINS_OE_N[g])
      );
    end
  endgenerate

  // Scan inputs use the synchronised copies: TCK is far below I_CLK/4 only
  // if the programmer runs slowly, a limit the user must respect
  assign O_JTAG_TMS    = jtag_en & pc_in[0];
  assign O_JTAG_TCK    = jtag_en & pc_in[1];
  assign O_JTAG_TDI    = jtag_en & pc_in[5];
  assign O_JTAG_ACTIVE = jtag_en;

  assign O_PORT_B_LOGIC_IN = pb_in;
  assign O_PORT_C_LOGIC_IN = pc_in;
  assign O_ADDR_BIT16      = pc_in[2];
  assign O_ADDR_BIT17      = pc_in[7];

  // Host lanes: index 0 is DSP data bit 8, index 7 is bit 15
  assign O_HOST_WRITE_DATA   = hd_in;
  assign O_BYTE_SPACE_ACCESS = ~bms_n;

  // Read is held off while a system reset is asserted
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MEM_READ <= 1'b0;
      mem_data   <= 8'h00;
      mem_read_d <= 1'b0;
      busy_d     <= 1'b0;
    end else begin
      O_MEM_READ <= ~rd_n & ~bms_n & sys_rst_n;
      mem_read_d <= O_MEM_READ;
      busy_d     <= I_FLASH_BUSY;
      if (O_MEM_READ) begin
        mem_data <= I_MEM_RDATA;
      end
    end
  end

  // Lanes are driven only while the strobe is seen low
  assign O_HOST_DATA_PINS      = mem_data;
  assign O_HOST_DATA_PINS_OE_N = ~(O_MEM_READ & ~rd_n);

  // Busy falling marks a finished program or erase
  assign done_evt    = busy_d & ~I_FLASH_BUSY;
  assign byte_rd_evt = O_MEM_READ & ~mem_read_d;

  // Sticky status; a new event beats a same-cycle clear
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      int_status <= 2'h0;
    end else if (sys_clr) begin
      int_status <= 2'h0;
    end else begin
      int_status <= (int_status & ~({2{wr_int_status}} & I_WDATA[1:0])) |
                    {byte_rd_evt, done_evt};
    end
  end

  assign O_IRQ = |(int_status & int_mask);

  always @* begin
    next_rdata = 8'h00;
    if (I_RD) begin
      case (I_ADDR)
        `DPPM_PB_OUT:     next_rdata = pb_out;
        `DPPM_PB_DIR:     next_rdata = pb_dir;
        `DPPM_PB_MCELL:   next_rdata = pb_mcell;
        `DPPM_PB_MSRC:    next_rdata = pb_msrc;
        `DPPM_PB_SLEW:    next_rdata = {4'h0, pb_slew};
        `DPPM_PB_OD:      next_rdata = pb_od;
        `DPPM_PB_IN:      next_rdata = pb_in;
        `DPPM_PC_OUT:     next_rdata = pc_out;
        `DPPM_PC_DIR:     next_rdata = pc_dir;
        `DPPM_PC_MCELL:   next_rdata = pc_mcell;
        `DPPM_PC_OD:      next_rdata = pc_od;
        `DPPM_PC_IN:      next_rdata = pc_in;
        `DPPM_PROG_CTRL:  next_rdata = {5'h00, prog_ctrl};
        `DPPM_PAGE:       next_rdata = O_PAGE;
        `DPPM_INT_STATUS: next_rdata = {6'h00, int_status};
        `DPPM_INT_MASK:   next_rdata = {6'h00, int_mask};
        `DPPM_STATUS:     next_rdata = {6'h00, jtag_en, I_FLASH_BUSY};
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= next_rdata;
    end
  end
endmodule // dppm_top
`default_nettype wire

// >>> verif/dppm_checker.sv
/*
 Port checker for the pin-function multiplexer.
 Assumes one clock; pins pass a two-flop synchroniser.
*/
`timescale 1ns/1ns
`default_nettype none
module dppm_checker (
  input wire logic       I_CLK,
  input wire logic       I_RST,
  input wire logic       I_SYS_RESET_N,
  input wire logic       I_READ_STROBE_IN_N,
  input wire logic       I_BYTE_SPACE_SELECT_IN_N,
  input wire logic [7:0] I_HOST_DATA_PINS,
  input wire logic       O_HOST_DATA_PINS_OE_N,
  input wire logic [7:0] O_PORT_B_PINS_OE_N,
  input wire logic [7:0] O_PORT_C_PINS_OE_N,
  input wire logic [3:0] O_PORT_B_FAST_SLEW,
  input wire logic [7:0] I_PORT_C_PINS,
  input wire logic       O_ADDR_BIT16,
  input wire logic       O_ADDR_BIT17,
  input wire logic       O_MEM_READ,
  input wire logic       O_BYTE_SPACE_ACCESS,
  input wire logic [7:0] O_HOST_WRITE_DATA,
  input wire logic [7:0] O_PAGE,
  input wire logic       O_JTAG_TMS,
  input wire logic       O_JTAG_TCK,
  input wire logic       O_JTAG_TDI,
  input wire logic       O_JTAG_ACTIVE,
  input wire logic       I_RD,
  input wire logic [7:0] O_RDATA
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  a_read_gated:
  assert property (O_MEM_READ |-> !$past(I_READ_STROBE_IN_N, 3)
    && !$past(I_BYTE_SPACE_SELECT_IN_N, 3))
    else $error("Memory read without strobe and select");
  a_lanes_on_read:
  // Lanes follow the synchronised strobe: drive starts three edges and stops two edges after the pin
  assert property (!O_HOST_DATA_PINS_OE_N |-> !$past(I_READ_STROBE_IN_N, 2))
    else $error("Host lanes driven without read strobe");
  a_lanes_drive:
  assert property (O_MEM_READ && !I_READ_STROBE_IN_N |-> !O_HOST_DATA_PINS_OE_N)
    else $error("Host lanes not driven during read");
  // Sync flops may hold their reset value for the first edges
  a_select_sync:
  assert property (!$past(I_RST, 3) |->
    O_BYTE_SPACE_ACCESS == !$past(I_BYTE_SPACE_SELECT_IN_N, 2))
    else $error("Byte space select not followed");
  a_lane_order:
  assert property (!$past(I_RST, 3) |->
    O_HOST_WRITE_DATA == $past(I_HOST_DATA_PINS, 2))
    else $error("Host lane order wrong");
  a_addr_bits:
  assert property (!$past(I_RST, 3) |-> O_ADDR_BIT16 == $past(I_PORT_C_PINS[2], 2)
    && O_ADDR_BIT17 == $past(I_PORT_C_PINS[7], 2))
    else $error("Address bits not taken from port C");
  a_jtag_gated:
  assert property (!O_JTAG_ACTIVE |-> {O_JTAG_TMS, O_JTAG_TCK, O_JTAG_TDI} == 3'b000)
    else $error("Scan signals pass while disabled");
  a_rdata_once:
  assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("Read data outside its cycle");
  a_sys_reset:
  assert property (!I_SYS_RESET_N [*5] |-> O_PORT_B_PINS_OE_N == 8'hff
    && O_PORT_C_PINS_OE_N == 8'hff && O_PAGE == 8'h00
    && O_PORT_B_FAST_SLEW == 4'h0 && !O_JTAG_ACTIVE)
    else $error("System reset did not clear ports");
endmodule // dppm_checker
bind dppm_top dppm_checker u_dppm_checker (.*);
`default_nettype wire

// >>> verif/dppm_dsp_host.sv
/*
 DSP host model: read strobe, byte-memory select and host data lanes.
 Assumes the device drives the lanes only while its enable is low.
*/
`timescale 1ns/1ns
`default_nettype none
module dppm_dsp_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_dev_data,
  input  wire logic       i_dev_oe_n,
  output var  logic       o_rd_n,
  output var  logic       o_bms_n,
  output wire logic [7:0] o_lanes
);
  logic [7:0] val;
  logic       drv;
  initial begin
    o_rd_n  = 1'b1;
    o_bms_n = 1'b1;
    drv     = 1'b0;
    val     = 8'h00;
  end
  // Released lanes float, so they show the inverse of the last value
  assign o_lanes = !i_dev_oe_n ? i_dev_data : drv ? val : ~val;
  task put(input logic [7:0] v);
    @(posedge i_clk);
    val <= v;
    drv <= 1'b1;
  endtask
  task free_lanes;
    @(posedge i_clk);
    drv <= 1'b0;
  endtask
  // Strobes stay low for hold+1 cycles; the byte is taken after hold cycles, before release
  task bread(input logic sel, input int hold, output logic [7:0] got);
    @(posedge i_clk);
    o_rd_n  <= 1'b0;
    o_bms_n <= !sel;
    repeat (hold) @(posedge i_clk);
    #1 got = o_lanes;
    @(posedge i_clk);
    o_rd_n  <= 1'b1;
    o_bms_n <= 1'b1;
  endtask
endmodule // dppm_dsp_host
`default_nettype wire

// >>> verif/dppm_tb_top.sv
/*
 Self-checking bench for the pin-function multiplexer.
 Assumes the DSP host model and bound checker; pins resolved here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dppm_defines.vh"
module dppm_tb_top;
  logic       clk, rst, sys_n, busy, tdo, est, eer, wr, rd;
  logic [7:0] addr, wdata, ab, bc, mdat, pb_ext, pc_ext, d;
  wire        rd_n, bms_n, hd_oe_n, jact, tms, tck, tdi, irq;
  wire  [3:0] slew;
  wire  [7:0] lanes, hd_o, pb_o, pb_oe, pc_o, pc_oe, pb_li, page, rdata;
  wire  [7:0] pb_pin, pc_pin, pc_li;
  int         mismatches, n_compared, cyc;
  assign pb_pin = (pb_o & ~pb_oe) | (pb_ext & pb_oe);
  assign pc_pin = (pc_o & ~pc_oe) | (pc_ext & pc_oe);
  dppm_top u_dppm_top (
    .I_CLK(clk), .I_RST(rst), .I_SYS_RESET_N(sys_n),
    .I_READ_STROBE_IN_N(rd_n), .I_BYTE_SPACE_SELECT_IN_N(bms_n),
    .I_HOST_DATA_PINS(lanes), .O_HOST_DATA_PINS(hd_o),
    .O_HOST_DATA_PINS_OE_N(hd_oe_n), .I_PORT_B_PINS(pb_pin),
    .O_PORT_B_PINS(pb_o), .O_PORT_B_PINS_OE_N(pb_oe),
    .O_PORT_B_FAST_SLEW(slew), .I_PORT_C_PINS(pc_pin), .O_PORT_C_PINS(pc_o),
    .O_PORT_C_PINS_OE_N(pc_oe), .I_OUTPUT_MACROCELL_GROUP_AB(ab),
    .I_OUTPUT_MACROCELL_GROUP_BC(bc), .O_PORT_B_LOGIC_IN(pb_li),
    .O_PORT_C_LOGIC_IN(pc_li), .O_ADDR_BIT16(), .O_ADDR_BIT17(),
    .I_MEM_RDATA(mdat), .O_MEM_READ(), .O_BYTE_SPACE_ACCESS(),
    .O_HOST_WRITE_DATA(), .O_PAGE(page), .I_FLASH_BUSY(busy),
    .I_JTAG_TDO(tdo), .I_ENHANCED_PROGRAM_STATUS(est),
    .I_ENHANCED_PROGRAM_ERROR(eer), .O_JTAG_TMS(tms), .O_JTAG_TCK(tck),
    .O_JTAG_TDI(tdi), .O_JTAG_ACTIVE(jact), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq)
  );
  dppm_dsp_host u_dppm_dsp_host (
    .i_clk(clk), .i_dev_data(hd_o), .i_dev_oe_n(hd_oe_n),
    .o_rd_n(rd_n), .o_bms_n(bms_n), .o_lanes(lanes)
  );
  task results;
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task w(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task r(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Every place from 0x00 to 0x15, mapped or not, reads zero after reset
  task t_reset;
    for (int i = 0; i < 22; i++) begin
      r(i[7:0], d); chk(d, 8'h00);
    end
    chk(pb_oe, 8'hff); chk(pc_oe, 8'hff); chk({4'h0, slew}, 8'h00);
  endtask
  task t_port_b;
    w(`DPPM_PB_DIR, 8'hff); w(`DPPM_PB_OUT, 8'ha5); idle(2);
    chk(pb_o, 8'ha5); chk(pb_oe, 8'h00);
    idle(3); r(`DPPM_PB_IN, d); chk(d, 8'ha5);
    w(`DPPM_PB_MCELL, 8'hff); idle(2); chk(pb_o, 8'h5a);
    w(`DPPM_PB_MSRC, 8'hff); idle(2); chk(pb_o, 8'hc3);
    w(`DPPM_PB_MCELL, 8'h00); w(`DPPM_PB_DIR, 8'h00);
    @(posedge clk) pb_ext <= 8'h3c;
    idle(5); chk(pb_oe, 8'hff); chk(pb_li, 8'h3c);
    r(`DPPM_PB_IN, d); chk(d, 8'h3c);
  endtask
  task t_drive;
    w(`DPPM_PB_SLEW, 8'hff); idle(2); chk({4'h0, slew}, 8'h0f);
    r(`DPPM_PB_SLEW, d); chk(d, 8'h0f);
    w(`DPPM_PB_OD, 8'hff); r(`DPPM_PB_OD, d); chk(d, 8'hf8);
    w(`DPPM_PB_DIR, 8'hff); w(`DPPM_PB_OUT, 8'hff); idle(2);
    chk(pb_oe, 8'hf8);
    w(`DPPM_PB_OUT, 8'h00); idle(2); chk(pb_oe, 8'h00);
    w(`DPPM_PB_SLEW, 8'h00); idle(2); chk({4'h0, slew}, 8'h00);
  endtask
  task t_port_c;
    w(`DPPM_PC_DIR, 8'hff); w(`DPPM_PC_OUT, 8'h0f); w(`DPPM_PC_OD, 8'hff);
    idle(2); chk(pc_oe, 8'h0f); chk(pc_o & ~pc_oe, 8'h00);
    // Open drain only in direct I/O: macrocell keeps full drive
    w(`DPPM_PC_MCELL, 8'hff); idle(2); chk(pc_o, 8'hc3); chk(pc_oe, 8'h00);
    w(`DPPM_PC_MCELL, 8'h00); w(`DPPM_PC_DIR, 8'h00); w(`DPPM_PC_OD, 8'h00);
  endtask
  task t_prog;
    @(posedge clk);
    pc_ext <= 8'ha5; tdo <= 1'b1; est <= 1'b1; eer <= 1'b0;
    w(`DPPM_PROG_CTRL, 8'h01); idle(4);
    chk({4'h0, jact, tms, tck, tdi}, 8'h0d);
    chk({6'h0, pc_oe[6], pc_o[6]}, 8'h01);
    chk(pc_li, 8'he5);
    w(`DPPM_PROG_CTRL, 8'h03); idle(2);
    chk({4'h0, pc_oe[4:3], pc_o[4:3]}, 8'h01);
    w(`DPPM_PROG_CTRL, 8'h04);
    @(posedge clk) busy <= 1'b1;
    idle(3); chk({6'h0, pc_oe[3], pc_o[3]}, 8'h00);
    @(posedge clk) busy <= 1'b0;
    idle(3); chk({6'h0, pc_oe[3], pc_o[3]}, 8'h01);
    chk({7'h0, irq}, 8'h00);
    w(`DPPM_PROG_CTRL, 8'h00); idle(2); chk({7'h0, jact}, 8'h00);
  endtask
  task t_irq;
    r(`DPPM_INT_STATUS, d); chk(d, 8'h01);
    w(`DPPM_INT_STATUS, 8'hff); w(`DPPM_INT_MASK, 8'h01);
    @(posedge clk) busy <= 1'b1;
    @(posedge clk) busy <= 1'b0;
    idle(3); chk({7'h0, irq}, 8'h01);
    w(`DPPM_INT_MASK, 8'h00); idle(1); chk({7'h0, irq}, 8'h00);
    w(`DPPM_INT_MASK, 8'h01); idle(1); chk({7'h0, irq}, 8'h01);
    w(`DPPM_INT_STATUS, 8'h01); idle(2); chk({7'h0, irq}, 8'h00);
    r(`DPPM_INT_STATUS, d); chk(d, 8'h00);
  endtask
  task t_host;
    u_dppm_dsp_host.put(8'h81); idle(4);
    u_dppm_dsp_host.free_lanes();
    u_dppm_dsp_host.bread(1'b1, 6, d); chk(d, 8'h96);
    r(`DPPM_INT_STATUS, d); chk(d, 8'h02);
    w(`DPPM_INT_STATUS, 8'h02);
    // Select high: no read, so the lanes stay released
    u_dppm_dsp_host.bread(1'b0, 6, d); chk(d, 8'h7e);
    r(`DPPM_INT_STATUS, d); chk(d, 8'h00);
  endtask
  task t_sys_reset;
    w(`DPPM_PAGE, 8'h42); idle(2); chk(page, 8'h42);
    w(`DPPM_PB_DIR, 8'hff);
    @(posedge clk) sys_n <= 1'b0;
    idle(3); w(`DPPM_PAGE, 8'h11); idle(3);
    chk(page, 8'h00); chk(pb_oe, 8'hff);
    @(posedge clk) sys_n <= 1'b1;
    idle(3); r(`DPPM_PAGE, d); chk(d, 8'h00);
    r(`DPPM_PB_DIR, d); chk(d, 8'h00);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    rst = 1'b1; sys_n = 1'b0; busy = 1'b0; tdo = 1'b0; est = 1'b0;
    eer = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    ab = 8'h5a; bc = 8'hc3; mdat = 8'h96; pb_ext = 8'h00; pc_ext = 8'h00;
    mismatches = 0; n_compared = 0; cyc = 0;
    // Reset pin is low for the first 10 of the 20 power-up cycles
    repeat (10) @(posedge clk);
    sys_n <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset(); t_port_b(); t_drive(); t_port_c(); t_prog();
    t_irq(); t_host(); t_sys_reset();
    results();
  end
endmodule // dppm_tb_top
`default_nettype wire
